/* File: core/t16_edge.sv */
// Sampled trigger edge detector with two-sample noise rejection
`timescale 1ns/1ps
`include "t16_map.svh"
module t16_edge (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic sample_i,
    input wire logic pin_i,
    input wire logic [1:0] edge_sel_i,
    output logic edge_o
);
    logic last_ff;
    logic level_ff;
    logic edge_ff;
    // Level starts low, so a pin already high at reset reads as rising
    wire settle = sample_i && (last_ff == pin_i) && (pin_i != level_ff);
    wire want = pin_i ? (edge_sel_i == `T16_ES_RISE ||
                         edge_sel_i == `T16_ES_BOTH)
                      : (edge_sel_i == `T16_ES_FALL ||
                         edge_sel_i == `T16_ES_BOTH);
    wire nxt_edge = settle && want;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_ff <= 1'b0;
            level_ff <= 1'b0;
            edge_ff <= 1'b0;
        end else begin
            if (sample_i) begin
                last_ff <= pin_i;
            end
            if (settle) begin
                level_ff <= pin_i;
            end
            edge_ff <= nxt_edge;
        end
    end
    assign edge_o = edge_ff;
endmodule

/* File: core/t16_map.svh */
// Constants for the 16-bit capture/one-shot timer
`ifndef T16_MAP_SVH
`define T16_MAP_SVH

`define T16_MODE_STOP 2'h0
`define T16_MODE_CLR_EDGE 2'h1
`define T16_MODE_FREE 2'h2
`define T16_MODE_CLR_MATCH 2'h3

`define T16_CLK_DIV2 2'h0
`define T16_CLK_DIV4 2'h1
`define T16_CLK_EXT 2'h3
`define T16_MASK_DIV2 3'h1
`define T16_MASK_DIV4 3'h3
`define T16_MASK_DIV8 3'h7
`define T16_MASK_SAMP 3'h3
`define T16_PHASE_ZERO 3'h0
`define T16_PHASE_STEP 3'h1

`define T16_ES_FALL 2'h0
`define T16_ES_RISE 2'h1
`define T16_ES_BOTH 2'h3

`define T16_OC_ON 2'h3
`define T16_CNT_MAX 16'hFFFF
`define T16_CNT_ZERO 16'h0000
`define T16_CNT_ONE 16'h0001

`endif

/* File: core/t16_pkg.sv */
// Types shared by the timer modules
package t16_pkg;
    typedef enum logic [1:0] {
        T16_OS_IDLE,
        T16_OS_WAIT,
        T16_OS_ACTIVE
    } t16_os_state_t;
endpackage

/* File: core/t16_prescale.sv */
// Count clock generator: divided rise/fall strobes or external edge
`timescale 1ns/1ps
`include "t16_map.svh"
module t16_prescale (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [1:0] clk_sel_i,
    input wire logic ext_edge_i,
    t16_tick_if.src tick
);
    logic [2:0] div_ff;
    logic [2:0] nxt_div;
    wire ext = clk_sel_i == `T16_CLK_EXT;
    wire [2:0] mask = (clk_sel_i == `T16_CLK_DIV2) ? `T16_MASK_DIV2 :
                      (clk_sel_i == `T16_CLK_DIV4) ? `T16_MASK_DIV4 :
                      `T16_MASK_DIV8;
    wire [2:0] half = 3'((mask >> 1) + `T16_PHASE_STEP);
    wire [2:0] phase = div_ff & mask;

    // Free running so a start lands anywhere in the count period
    assign nxt_div = 3'(div_ff + `T16_PHASE_STEP);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_ff <= `T16_PHASE_ZERO;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // External edge gives rise and fall in the same cycle
    assign tick.rise = ext ? ext_edge_i : (phase == `T16_PHASE_ZERO);
    assign tick.fall = ext ? ext_edge_i : (phase == half);
    assign tick.samp = (div_ff & `T16_MASK_SAMP) == `T16_PHASE_ZERO;
endmodule

/* File: core/t16_tick_if.sv */
// Count clock strobes passed from prescaler to timer core
`timescale 1ns/1ps
interface t16_tick_if;
    logic rise;
    logic fall;
    logic samp;
    modport src (output rise, output fall, output samp);
    modport dst (input rise, input fall, input samp);
endinterface

/* File: core/t16_timer.sv */
// 16-bit timer/event counter with compare, capture and one-shot output
`timescale 1ns/1ps
`include "t16_map.svh"
module t16_timer (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic op_mode_bit_hi_i,
    input wire logic op_mode_bit_lo_i,
    input wire logic clk_sel_bit1_i,
    input wire logic clk_sel_bit0_i,
    input wire logic edge_sel_bit1_i,
    input wire logic edge_sel_bit0_i,
    input wire logic trigger_capture_in_a_i,
    input wire logic trigger_capture_in_b_i,
    input wire logic cap_a_mode_i,
    input wire logic cap_b_mode_i,
    input wire logic cmp_a_wr_i,
    input wire logic cmp_b_wr_i,
    input wire logic [15:0] cmp_wdata_i,
    input wire logic ovf_clr_i,
    input wire logic [1:0] out_ctrl_en_i,
    input wire logic timer_out_enable_bit_i,
    input wire logic out_level_set_bit_i,
    input wire logic out_level_reset_bit_i,
    input wire logic invert_on_edge_bit_i,
    input wire logic invert_on_match_i,
    input wire logic oneshot_en_i,
    input wire logic oneshot_soft_trigger_i,
    input wire logic out_route_b_i,
    output logic [15:0] count_value_o,
    output logic [15:0] cmp_cap_reg_a_o,
    output logic [15:0] cmp_cap_reg_b_o,
    output logic overflow_flag_o,
    output logic match_a_o,
    output logic match_b_o,
    output logic capture_irq_a_o,
    output logic capture_irq_b_o,
    output logic oneshot_busy_o,
    output logic timer_out_pin_o,
    output logic port_location_a_o,
    output logic port_location_a_oe_o,
    output logic port_location_b_o,
    output logic port_location_b_oe_o
);
    ////////////////////////////////////////////////////////////////////
    // Configuration decode

    wire [1:0] mode = {op_mode_bit_hi_i, op_mode_bit_lo_i};
    wire [1:0] clk_sel = {clk_sel_bit1_i, clk_sel_bit0_i};
    wire running = mode != `T16_MODE_STOP;
    wire ext_clk = clk_sel == `T16_CLK_EXT;
    wire mode_clr_edge = mode == `T16_MODE_CLR_EDGE;
    wire mode_clr_match = mode == `T16_MODE_CLR_MATCH;
    wire mode_free = mode == `T16_MODE_FREE;

    logic [1:0] edge_sel_ff;
    logic [15:0] count_ff;
    logic [15:0] cmp_a_ff;
    logic [15:0] cmp_b_ff;
    logic ovf_ff;
    logic ovf_hold_ff;
    logic clr_pend_ff;
    logic cap_a_pend_ff;
    logic cap_b_pend_ff;
    logic irq_a_pend_ff;
    logic irq_b_pend_ff;
    logic irq_a_ff;
    logic irq_b_ff;
    logic match_a_ff;
    logic match_b_ff;
    logic out_ff;
    t16_pkg::t16_os_state_t os_ff;
    t16_pkg::t16_os_state_t nxt_os;

    ////////////////////////////////////////////////////////////////////
    // Count clock and trigger inputs

    t16_tick_if tick ();
    logic edge_a_raw;
    logic edge_b;

    // In edge-clocked counting, sample at the fixed quarter rate
    wire samp_a = ext_clk ? tick.samp : tick.rise;

    t16_edge u_edge_a (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .sample_i (samp_a),
        .pin_i (trigger_capture_in_a_i),
        .edge_sel_i (edge_sel_ff),
        .edge_o (edge_a_raw)
    );

    t16_edge u_edge_b (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .sample_i (tick.rise),
        .pin_i (trigger_capture_in_b_i),
        .edge_sel_i (edge_sel_ff),
        .edge_o (edge_b)
    );

    // Pin shared with the output on location B is lost as a trigger
    wire edge_a = edge_a_raw && !out_route_b_i;

    t16_prescale u_prescale (
        .ref_clk_i (ref_clk_i),
        .rst_i (rst_i),
        .clk_sel_i (clk_sel),
        .ext_edge_i (edge_a),
        .tick (tick)
    );

    ////////////////////////////////////////////////////////////////////
    // Counter, compare and overflow

    function automatic logic hit(input logic [15:0] cnt,
                                 input logic [15:0] cmp);
        hit = cnt == cmp;
    endfunction

    wire step = running && tick.rise;
    wire hit_a = hit(count_ff, cmp_a_ff);
    wire hit_b = hit(count_ff, cmp_b_ff);
    wire wrap = hit(count_ff, `T16_CNT_MAX);
    wire clr_edge = mode_clr_edge && (clr_pend_ff || edge_a);
    wire clr_match = mode_clr_match && hit_a;
    // A cleared FFFFH count is a wrap too, so it sets overflow
    wire ovf_evt = step && wrap;
    wire [15:0] nxt_count = !running ? `T16_CNT_ZERO :
        !step ? count_ff :
        (clr_edge || clr_match || wrap) ? `T16_CNT_ZERO :
        16'(count_ff + `T16_CNT_ONE);
    wire nxt_clr_pend = mode_clr_edge && !step &&
                        (clr_pend_ff || edge_a);
    // Clear is ignored until the count clock after the wrap
    wire nxt_ovf = ovf_evt ? 1'b1 :
        (ovf_clr_i && !ovf_hold_ff) ? 1'b0 : ovf_ff;
    wire nxt_hold = ovf_evt ? 1'b1 : (step ? 1'b0 : ovf_hold_ff);

    // Prescaler never restarts, so the first step after start may lag
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_ff <= `T16_CNT_ZERO;
            clr_pend_ff <= 1'b0;
            ovf_ff <= 1'b0;
            ovf_hold_ff <= 1'b0;
            match_a_ff <= 1'b0;
            match_b_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            clr_pend_ff <= nxt_clr_pend;
            ovf_ff <= nxt_ovf;
            ovf_hold_ff <= nxt_hold;
            match_a_ff <= step && hit_a && !cap_a_mode_i;
            match_b_ff <= step && hit_b && !cap_b_mode_i;
        end
    end

    // Edge choice is frozen while the timer runs
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            edge_sel_ff <= `T16_ES_FALL;
        end else if (!running) begin
            edge_sel_ff <= {edge_sel_bit1_i, edge_sel_bit0_i};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capture: latch on count clock fall, flag on the next rise

    // Input A cannot capture when it is also the count clock
    wire cap_b_ok = cap_b_mode_i && !ext_clk;
    wire cap_a_set = running && cap_a_mode_i && edge_b;
    wire cap_b_set = running && cap_b_ok && edge_a;
    wire cap_a_do = tick.fall && (cap_a_pend_ff || cap_a_set);
    wire cap_b_do = tick.fall && (cap_b_pend_ff || cap_b_set);
    wire nxt_cap_a_pend = running && !cap_a_do &&
                          (cap_a_pend_ff || cap_a_set);
    wire nxt_cap_b_pend = running && !cap_b_do &&
                          (cap_b_pend_ff || cap_b_set);
    wire nxt_irq_a_pend = running && (cap_a_do ||
                          (irq_a_pend_ff && !tick.rise));
    wire nxt_irq_b_pend = running && (cap_b_do ||
                          (irq_b_pend_ff && !tick.rise));
    // Reads see the register as is; a capture is never held off
    wire [15:0] nxt_cmp_a = cap_a_do ? count_ff :
        (cmp_a_wr_i && !cap_a_mode_i) ? cmp_wdata_i : cmp_a_ff;
    wire [15:0] nxt_cmp_b = cap_b_do ? count_ff :
        (cmp_b_wr_i && !cap_b_mode_i) ? cmp_wdata_i : cmp_b_ff;

    // Contents are left as they fall on stop; software must rewrite
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmp_a_ff <= `T16_CNT_ZERO;
            cmp_b_ff <= `T16_CNT_ZERO;
        end else begin
            cmp_a_ff <= nxt_cmp_a;
            cmp_b_ff <= nxt_cmp_b;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_a_pend_ff <= 1'b0;
            cap_b_pend_ff <= 1'b0;
            irq_a_pend_ff <= 1'b0;
            irq_b_pend_ff <= 1'b0;
            irq_a_ff <= 1'b0;
            irq_b_ff <= 1'b0;
        end else begin
            cap_a_pend_ff <= nxt_cap_a_pend;
            cap_b_pend_ff <= nxt_cap_b_pend;
            irq_a_pend_ff <= nxt_irq_a_pend;
            irq_b_pend_ff <= nxt_irq_b_pend;
            irq_a_ff <= irq_a_pend_ff && tick.rise;
            irq_b_ff <= irq_b_pend_ff && tick.rise;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // One-shot sequencer: start on trigger, active from B to A match

    // Clear-on-match mode would cut the pulse short, so it is refused
    wire os_mode_ok = oneshot_en_i &&
                      (mode_free || mode_clr_edge);
    // Edge start only from location A; soft start from either place
    wire os_trig = oneshot_soft_trigger_i || edge_a;
    wire os_on = step && hit_b;
    wire os_off = step && hit_a;

    always_comb begin
        nxt_os = os_ff;
        case (os_ff)
            t16_pkg::T16_OS_IDLE: begin
                if (os_mode_ok && os_trig) begin
                    nxt_os = t16_pkg::T16_OS_WAIT;
                end
            end
            // Triggers here are dropped, not queued
            t16_pkg::T16_OS_WAIT: begin
                if (!os_mode_ok) begin
                    nxt_os = t16_pkg::T16_OS_IDLE;
                end else if (os_on) begin
                    nxt_os = t16_pkg::T16_OS_ACTIVE;
                end
            end
            t16_pkg::T16_OS_ACTIVE: begin
                if (!os_mode_ok || os_off) begin
                    nxt_os = t16_pkg::T16_OS_IDLE;
                end
            end
            default: begin
                nxt_os = t16_pkg::T16_OS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Timer output level

    wire out_live = timer_out_enable_bit_i &&
                    (out_ctrl_en_i == `T16_OC_ON);
    wire os_edge = (os_ff == t16_pkg::T16_OS_WAIT &&
                    nxt_os == t16_pkg::T16_OS_ACTIVE) ||
                   (os_ff == t16_pkg::T16_OS_ACTIVE &&
                    nxt_os == t16_pkg::T16_OS_IDLE);
    wire inv_match = invert_on_match_i && !oneshot_en_i &&
                     step && (hit_a || hit_b);
    // Edge inversion only reaches the pin from location A
    wire inv_edge = invert_on_edge_bit_i && running && edge_a;
    wire toggle = out_live && (os_edge || inv_match || inv_edge);
    // Direct level writes take effect only after the enables are set
    wire nxt_out = (out_live && out_level_set_bit_i) ? 1'b1 :
        (out_live && out_level_reset_bit_i) ? 1'b0 :
        (toggle ? !out_ff : out_ff);

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            os_ff <= t16_pkg::T16_OS_IDLE;
            out_ff <= 1'b0;
        end else begin
            os_ff <= nxt_os;
            out_ff <= nxt_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    assign count_value_o = count_ff;
    assign cmp_cap_reg_a_o = cmp_a_ff;
    assign cmp_cap_reg_b_o = cmp_b_ff;
    assign overflow_flag_o = ovf_ff;
    assign match_a_o = match_a_ff;
    assign match_b_o = match_b_ff;
    assign capture_irq_a_o = irq_a_ff;
    assign capture_irq_b_o = irq_b_ff;
    assign oneshot_busy_o = os_ff != t16_pkg::T16_OS_IDLE;
    assign timer_out_pin_o = out_ff;
    assign port_location_a_o = out_ff;
    assign port_location_a_oe_o = out_live && !out_route_b_i;
    assign port_location_b_o = out_ff;
    assign port_location_b_oe_o = out_live && out_route_b_i;
endmodule

/* File: verification/t16_pin_model.sv */
// Pin-side model: trigger sources and output pad loads
`timescale 1ns/1ps
module t16_pin_model (
    input wire logic ref_clk_i,
    input wire logic pad_a_i,
    input wire logic pad_a_oe_i,
    input wire logic pad_b_i,
    input wire logic pad_b_oe_i,
    output logic trig_a_o,
    output logic trig_b_o,
    output logic pad_a_o,
    output logic pad_b_o
);
    logic lvl_a = 1'b0;
    logic lvl_b = 1'b0;
    // Released pad A rests on its pull-up
    assign pad_a_o = pad_a_oe_i ? pad_a_i : 1'b1;
    // Location B is the trigger A pin, so driving it hides the source
    assign pad_b_o = pad_b_oe_i ? pad_b_i : lvl_a;
    assign trig_a_o = pad_b_o;
    assign trig_b_o = lvl_b;
    // Exact capture needs width above two count clocks
    task automatic pulse(input bit sel, input int width);
        @(posedge ref_clk_i);
        lvl_a <= !sel;
        lvl_b <= sel;
        repeat (width) @(posedge ref_clk_i);
        lvl_a <= 1'b0;
        lvl_b <= 1'b0;
    endtask
endmodule

/* File: verification/t16_timer_bench.sv */
// Self-checking bench for the 16-bit capture/one-shot timer
`timescale 1ns/1ps
module t16_timer_bench;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [1:0] csel = 2'h0;
    logic [1:0] esel = 2'h0;
    logic [3:0] strb = 4'h0;
    logic cap_a_mode_i = 1'b0;
    logic cap_b_mode_i = 1'b0;
    logic cmp_a_wr_i = 1'b0;
    logic cmp_b_wr_i = 1'b0;
    logic [15:0] cmp_wdata_i = 16'h0000;
    logic [1:0] out_ctrl_en_i = 2'h0;
    logic timer_out_enable_bit_i = 1'b0;
    logic oneshot_en_i = 1'b0;
    logic out_route_b_i = 1'b0;
    logic invert_on_edge_bit_i = 1'b0;
    logic trig_a, trig_b, pad_a, pad_b;
    logic [15:0] count_value_o, cmp_cap_reg_a_o, cmp_cap_reg_b_o;
    logic overflow_flag_o, match_a_o, capture_irq_a_o, capture_irq_b_o;
    logic oneshot_busy_o, timer_out_pin_o;
    logic port_location_a_o, port_location_a_oe_o;
    logic port_location_b_o, port_location_b_oe_o;
    logic [3:0] flags;
    int err_count = 0;
    int n_tests = 0;
    int seed = 9933;
    t16_timer DUT (
        .ref_clk_i, .rst_i, .op_mode_bit_hi_i(mode[1]),
        .op_mode_bit_lo_i(mode[0]), .clk_sel_bit1_i(csel[1]),
        .clk_sel_bit0_i(csel[0]), .edge_sel_bit1_i(esel[1]),
        .edge_sel_bit0_i(esel[0]), .trigger_capture_in_a_i(trig_a),
        .trigger_capture_in_b_i(trig_b), .cap_a_mode_i, .cap_b_mode_i,
        .cmp_a_wr_i, .cmp_b_wr_i, .cmp_wdata_i, .ovf_clr_i(strb[0]),
        .out_ctrl_en_i, .timer_out_enable_bit_i,
        .out_level_set_bit_i(strb[1]), .out_level_reset_bit_i(strb[2]),
        .invert_on_edge_bit_i, .invert_on_match_i(1'b0),
        .oneshot_en_i, .oneshot_soft_trigger_i(strb[3]), .out_route_b_i,
        .count_value_o, .cmp_cap_reg_a_o, .cmp_cap_reg_b_o,
        .overflow_flag_o, .match_a_o, .match_b_o(), .capture_irq_a_o,
        .capture_irq_b_o, .oneshot_busy_o, .timer_out_pin_o,
        .port_location_a_o, .port_location_a_oe_o, .port_location_b_o,
        .port_location_b_oe_o);
    t16_pin_model pm (.ref_clk_i, .pad_a_i(port_location_a_o),
        .pad_a_oe_i(port_location_a_oe_o), .pad_b_i(port_location_b_o),
        .pad_b_oe_i(port_location_b_oe_o), .trig_a_o(trig_a),
        .trig_b_o(trig_b), .pad_a_o(pad_a), .pad_b_o(pad_b));
    assign flags = {oneshot_busy_o, capture_irq_b_o, capture_irq_a_o,
        match_a_o};
    always #2 ref_clk_i = ~ref_clk_i;
    ////////////////////////////////////////////////////////////
    function automatic logic [15:0] exp_steps(input int sel, input int cyc);
        return 16'(cyc >> (sel + 1));
    endfunction
    task automatic cmp_val(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp,
        input logic got);
        cmp_val(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic done(input string name);
        $display("%s done, %0d mismatches so far", name, err_count);
    endtask
    task automatic drive_mode(input logic [1:0] m);
        @(posedge ref_clk_i);
        mode <= m;
    endtask
    task automatic strobe(input int idx);
        @(posedge ref_clk_i);
        strb[idx] <= 1'b1;
        @(posedge ref_clk_i);
        strb[idx] <= 1'b0;
        #1;
    endtask
    task automatic wait_flag(input int idx, input int lim, output bit hit);
        hit = 0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge ref_clk_i);
            #1;
            hit = (flags[idx] === 1'b1);
        end
    endtask
    task automatic write_cmp(input logic [15:0] a, input logic [15:0] b);
        @(posedge ref_clk_i);
        cmp_wdata_i <= a;
        cmp_a_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        cmp_a_wr_i <= 1'b0;
        cmp_wdata_i <= b;
        cmp_b_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        cmp_b_wr_i <= 1'b0;
    endtask
    task automatic finish_test;
        $display("Totals: %0d checks, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        #700000;
        err_count++;
        $display("[FAIL] watchdog expected done seen hang");
        finish_test();
    end
    initial begin
        logic [15:0] c0;
        logic [15:0] r;
        logic [1:0] m_tab [4];
        bit hit;
        int hi;
        m_tab = '{2'h2, 2'h1, 2'h3, 2'h2};
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        cmp_val("count after reset", 16'h0000, count_value_o);
        cmp_bit("overflow after reset", 1'b0, overflow_flag_o);
        // Divider rates only
        for (int s = 0; s < 3; s++) begin
            drive_mode(2'h0);
            csel <= 2'(s);
            drive_mode(2'h2);
            @(posedge ref_clk_i);
            #1 c0 = count_value_o;
            repeat (24) @(posedge ref_clk_i);
            #1 cmp_val("steps", exp_steps(s, 24), count_value_o - c0);
        end
        csel <= 2'h0;
        done("rate");
        for (int k = 0; k < 3; k++) begin
            drive_mode(2'h0);
            r = 16'h0010 + (16'($random(seed)) & 16'h00FF);
            write_cmp(r, r + 16'h0010);
            drive_mode(2'h2);
            wait_flag(0, 1200, hit);
            cmp_bit("match seen", 1'b1, hit);
            cmp_val("count at match", r + 16'h0001, count_value_o);
        end
        done("match");
        drive_mode(2'h0);
        esel <= 2'h3;
        cap_a_mode_i <= 1'b1;
        cap_b_mode_i <= 1'b1;
        drive_mode(2'h2);
        for (int sel = 0; sel < 2; sel++) begin
            pm.pulse(sel[0], 1);
            wait_flag(2 - sel, 40, hit);
            cmp_bit("glitch capture", 1'b0, hit);
            c0 = count_value_o;
            fork
                pm.pulse(sel[0], 20 + ($random(seed) & 15));
            join_none
            wait_flag(2 - sel, 60, hit);
            cmp_bit("capture irq", 1'b1, hit);
            r = sel ? cmp_cap_reg_a_o : cmp_cap_reg_b_o;
            cmp_bit("capture window", 1'b1, (r - c0) <= 16'h0006);
            repeat (90) @(posedge ref_clk_i);
        end
        done("capture");
        drive_mode(2'h0);
        cap_a_mode_i <= 1'b0;
        cap_b_mode_i <= 1'b0;
        oneshot_en_i <= 1'b1;
        out_ctrl_en_i <= 2'h3;
        @(posedge ref_clk_i);
        timer_out_enable_bit_i <= 1'b1;
        strobe(1);
        cmp_bit("level set", 1'b1, timer_out_pin_o);
        strobe(2);
        cmp_bit("level reset", 1'b0, timer_out_pin_o);
        for (int i = 0; i < 4; i++) begin
            drive_mode(2'h0);
            out_route_b_i <= (i == 3);
            write_cmp(16'h0028, 16'h0014);
            drive_mode(m_tab[i]);
            strobe(3);
            wait_flag(3, 4, hit);
            cmp_bit("one-shot start", m_tab[i] != 2'h3, hit);
            hi = 0;
            repeat (300) begin
                @(posedge ref_clk_i);
                #1 hi += ((out_route_b_i ? pad_b : pad_a) === 1'b1);
            end
            cmp_val("active cycles", (m_tab[i] != 2'h3) ? 16'h0028 : 16'h0000,
                16'(hi));
            cmp_bit("one-shot idle", 1'b0, oneshot_busy_o);
        end
        done("one-shot");
        drive_mode(2'h0);
        oneshot_en_i <= 1'b0;
        out_route_b_i <= 1'b0;
        invert_on_edge_bit_i <= 1'b1;
        write_cmp(16'hFFFF, 16'h0100);
        drive_mode(2'h3);
        pm.pulse(1'b0, 8);
        #1 cmp_bit("edge invert", 1'b1, timer_out_pin_o);
        for (int i = 0; i < 140000 && count_value_o !== 16'hFFFF; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        // Clear held over wrap and zero count
        @(posedge ref_clk_i);
        strb[0] <= 1'b1;
        @(posedge ref_clk_i);
        @(posedge ref_clk_i);
        strb[0] <= 1'b0;
        #1 cmp_val("count after wrap", 16'h0000, count_value_o);
        cmp_bit("overflow kept", 1'b1, overflow_flag_o);
        repeat (4) @(posedge ref_clk_i);
        strobe(0);
        cmp_bit("overflow cleared", 1'b0, overflow_flag_o);
        done("overflow");
        finish_test();
    end
endmodule

/* File: verification/t16_timer_properties.sv */
// Port-level assertions for the timer, bound to its top module
`timescale 1ns/1ps
module t16_timer_properties (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic op_mode_bit_hi_i,
    input wire logic op_mode_bit_lo_i,
    input wire logic trigger_capture_in_a_i,
    input wire logic cap_a_mode_i,
    input wire logic ovf_clr_i,
    input wire logic out_route_b_i,
    input wire logic [15:0] count_value_o,
    input wire logic [15:0] cmp_cap_reg_a_o,
    input wire logic overflow_flag_o,
    input wire logic match_a_o,
    input wire logic capture_irq_a_o,
    input wire logic capture_irq_b_o,
    input wire logic oneshot_busy_o,
    input wire logic port_location_a_oe_o,
    input wire logic port_location_b_oe_o
);
    logic [1:0] mode;
    logic a_last_ff;
    logic [7:0] a_age_ff;
    logic [7:0] nxt_a_age;
    logic [7:0] rb_age_ff;
    logic [7:0] nxt_rb_age;
    assign mode = {op_mode_bit_hi_i, op_mode_bit_lo_i};
    // Saturating ages: since input A moved, and time spent on route B
    assign nxt_a_age = (trigger_capture_in_a_i != a_last_ff) ? 8'h00 :
        (a_age_ff == 8'hFF) ? 8'hFF : a_age_ff + 8'h01;
    assign nxt_rb_age = !out_route_b_i ? 8'h00 :
        (rb_age_ff == 8'hFF) ? 8'hFF : rb_age_ff + 8'h01;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_last_ff <= 1'b0;
            a_age_ff <= 8'hFF;
            rb_age_ff <= 8'h00;
        end else begin
            a_last_ff <= trigger_capture_in_a_i;
            a_age_ff <= nxt_a_age;
            rb_age_ff <= nxt_rb_age;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    chk_count_step: assert property (
        $changed(count_value_o) && count_value_o != 16'h0000
        |-> count_value_o == $past(count_value_o) + 16'h0001)
        else $error("count moved by other than one");
    chk_wrap_ovf: assert property (
        count_value_o == 16'h0000 && $past(count_value_o) == 16'hFFFF
        && $past(mode) != 2'h0 |-> overflow_flag_o)
        else $error("wrap without overflow flag");
    chk_ovf_hold: assert property (
        count_value_o == 16'h0000 && $past(count_value_o) == 16'hFFFF
        && $past(mode) != 2'h0 && ovf_clr_i |=> overflow_flag_o)
        else $error("early overflow clear took effect");
    chk_ovf_clear: assert property (
        overflow_flag_o && ovf_clr_i && count_value_o != 16'h0000
        && count_value_o != 16'hFFFF |=> !overflow_flag_o)
        else $error("overflow clear ignored");
    chk_cap_value: assert property (
        capture_irq_a_o && cap_a_mode_i && mode == 2'h2
        |-> cmp_cap_reg_a_o == count_value_o - 16'h0001)
        else $error("captured value not count at fall");
    chk_edge_filter: assert property (
        capture_irq_b_o |-> a_age_ff >= 8'h02 && a_age_ff <= 8'h40)
        else $error("capture without settled edge on input A");
    chk_match_count: assert property (
        match_a_o && mode == 2'h2
        |-> count_value_o == cmp_cap_reg_a_o + 16'h0001)
        else $error("match pulse off its count");
    chk_clr_match: assert property (
        match_a_o && mode == 2'h3 && $past(mode) == 2'h3
        |-> count_value_o == 16'h0000)
        else $error("match did not clear count");
    chk_oneshot_mode: assert property (
        $rose(oneshot_busy_o) |-> $past(mode) == 2'h1 || $past(mode) == 2'h2)
        else $error("one-shot started in wrong mode");
    chk_route_mute: assert property (
        rb_age_ff == 8'hFF |-> !capture_irq_b_o)
        else $error("input A active on route B");
    chk_oe_route: assert property (
        port_location_b_oe_o && out_route_b_i && $past(out_route_b_i)
        |-> !port_location_a_oe_o)
        else $error("both output locations driven");
    cov_wrap: cover property (overflow_flag_o && count_value_o == 16'h0000);
    cov_capture: cover property (capture_irq_a_o);
    cov_oneshot: cover property ($fell(oneshot_busy_o));
endmodule
bind t16_timer t16_timer_properties u_chk (.ref_clk_i, .rst_i,
    .op_mode_bit_hi_i, .op_mode_bit_lo_i, .trigger_capture_in_a_i,
    .cap_a_mode_i, .ovf_clr_i, .out_route_b_i, .count_value_o,
    .cmp_cap_reg_a_o, .overflow_flag_o, .match_a_o, .capture_irq_a_o,
    .capture_irq_b_o, .oneshot_busy_o, .port_location_a_oe_o,
    .port_location_b_oe_o);
